// ==== logic/cit_params.svh ====
`ifndef CIT_PARAMS_SVH
`define CIT_PARAMS_SVH

// ----------------------------------------
// csr addresses of the two timers
// ----------------------------------------
`define CIT_ADDR_COUNT0 12'h7D2
`define CIT_ADDR_BOUND0 12'h7D3
`define CIT_ADDR_CTL0 12'h7D4
`define CIT_ADDR_COUNT1 12'h7D5
`define CIT_ADDR_BOUND1 12'h7D6
`define CIT_ADDR_CTL1 12'h7D7

// ----------------------------------------
// reset values
// ----------------------------------------
`define CIT_COUNT_RESET 32'h00000000
`define CIT_BOUND_RESET 32'hFFFFFFFF
`define CIT_CTL_RESET 3'h1

// ----------------------------------------
// control field layout
// ----------------------------------------
`define CIT_CTL_WIDTH 3
`define CIT_CTL_ENABLE_BIT 0
`define CIT_CTL_HALT_EN_BIT 1
`define CIT_CTL_PAUSE_EN_BIT 2

// ----------------------------------------
// interrupt pending / enable positions
// ----------------------------------------
`define CIT_IRQ_T0_BIT 29
`define CIT_IRQ_T1_BIT 28

// ----------------------------------------
// interrupt cause codes, highest rank first
// ----------------------------------------
`define CIT_CAUSE_EXT 32'h8000000B
`define CIT_CAUSE_SW 32'h80000003
`define CIT_CAUSE_TMR 32'h80000007
`define CIT_CAUSE_T0 32'h8000001D
`define CIT_CAUSE_T1 32'h8000001C
`define CIT_CAUSE_NONE 32'h00000000

`endif

// ==== logic/cit_pkg.sv ====
`default_nettype none

package cit_pkg;

    // csr access from the core pipeline, one cycle request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } cit_csr_req_s;

    // core activity state seen by the timers
    typedef struct packed {
        logic sleep_state;
        logic pause;
        logic debug_mode;
        logic debug_step;
        logic debug_halted_state;
    } cit_core_state_s;

    // control register fields, bit 2 down to bit 0
    typedef struct packed {
        logic pause_en;
        logic halt_en;
        logic enable;
    } cit_ctl_s;

    // higher ranked standard machine interrupts, pending and enabled
    typedef struct packed {
        logic ext;
        logic sw;
        logic tmr;
    } cit_std_irq_s;

endpackage

`default_nettype wire

// ==== logic/cit_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cit_params.svh"

module cit_timer #(
    parameter int CW = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // increment qualifier and csr writes
    input wire logic inc_ok,
    input wire logic cnt_wr,
    input wire logic bnd_wr,
    input wire logic ctl_wr,
    input wire logic [CW-1:0] wdata,
    // register state
    output logic [CW-1:0] count,
    output logic [CW-1:0] bound,
    output cit_pkg::cit_ctl_s ctl,
    output logic hit
);

    // ----------------------------------------
    // bound compare
    // ----------------------------------------
    // unsigned compare, at or above counts as a hit
    assign hit = (count >= bound);

    // ----------------------------------------
    // counter
    // ----------------------------------------
    // write beats clear beats increment, so software sees its value
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            count <= CW'(`CIT_COUNT_RESET);
        end else if (cnt_wr) begin
            count <= wdata;
        end else if (hit) begin
            count <= '0;
        end else if (inc_ok) begin
            count <= count + CW'(1);
        end
    end

    // ----------------------------------------
    // bound and control
    // ----------------------------------------
    // bound takes any value
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bound <= CW'(`CIT_BOUND_RESET);
        end else if (bnd_wr) begin
            bound <= wdata;
        end
    end

    // only three bits stored, the rest never exist
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctl <= cit_pkg::cit_ctl_s'(`CIT_CTL_RESET);
        end else if (ctl_wr) begin
            ctl <= cit_pkg::cit_ctl_s'(wdata[`CIT_CTL_WIDTH-1:0]);
        end
    end

endmodule

`default_nettype wire

// ==== logic/cit_timers.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cit_params.svh"

// Overview of operation
// - two timers, each a 32-bit counter, 32-bit bound and control register
// - counters may advance on the first cycle after reset release
// - counter adds one every cycle its increment conditions hold
// - counters and bounds take any value; all registers readable and writable anytime
// - interrupt raised when counter is at or above bound, unsigned
// - counter at or above bound is cleared on the next cycle
// - counting needs enable, plus halt_en in sleep, pause_en when pausing
// - no counting in debug mode except while single stepping
// - single stepping counts every cycle the stepped instruction takes
// - timer interrupt never wakes the core out of debug halt
// - timer 0 pending and enable at bit 29, timer 1 at 28
// - timer interrupts rank below external, software and machine timer
// - cause 0x8000_001D for timer 0, 0x8000_001C for timer 1
// - timer 0 wins over timer 1 when both fire together
// - interrupt is not latched and lasts one cycle per hit
// - reserved control bits read zero and ignore writes
// - reset gives count zero, bound all ones, control enable only
// - pause_en lets counting run in pause; its interrupt ends pause
// - halt_en lets counting run in sleep; its interrupt wakes the core
// - control bit 0 is the general enable, reset to one
module cit_timers #(
    parameter int CW = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // csr access
    input wire cit_pkg::cit_csr_req_s csr_req,
    output logic [31:0] csr_rdata,
    output logic csr_hit,
    // core state and interrupt context
    input wire cit_pkg::cit_core_state_s core_state,
    input wire logic [31:0] mie,
    input wire cit_pkg::cit_std_irq_s std_irq,
    // interrupt and power outputs
    output logic [31:0] timer_irq_pending,
    output logic irq_take,
    output logic [31:0] irq_cause,
    output logic sleep_wake,
    output logic pause_exit
);

    // ----------------------------------------
    // per timer signals
    // ----------------------------------------
    logic [CW-1:0] count [2];
    logic [CW-1:0] bound [2];
    cit_pkg::cit_ctl_s ctl [2];
    logic [1:0] hit;
    logic [1:0] inc_ok;
    logic [1:0] cnt_wr;
    logic [1:0] bnd_wr;
    logic [1:0] ctl_wr;
    logic [1:0] timer_irq_enable;
    logic [1:0] irq_req;
    logic [1:0] halt_wake;
    logic [1:0] pause_wake;
    logic [31:0] next_rdata;
    logic next_hit;
    logic next_take;
    logic [31:0] next_cause;
    logic next_wake;
    logic next_pause_exit;

    // ----------------------------------------
    // interrupt enables from mie
    // ----------------------------------------
    // enables live in the standard register, we only look at them
    assign timer_irq_enable[0] = mie[`CIT_IRQ_T0_BIT];
    assign timer_irq_enable[1] = mie[`CIT_IRQ_T1_BIT];

    // ----------------------------------------
    // timer instances
    // ----------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_tmr
        localparam logic [11:0] ADDR_CNT = (i == 0) ? `CIT_ADDR_COUNT0 : `CIT_ADDR_COUNT1;
        localparam logic [11:0] ADDR_BND = (i == 0) ? `CIT_ADDR_BOUND0 : `CIT_ADDR_BOUND1;
        localparam logic [11:0] ADDR_CTL = (i == 0) ? `CIT_ADDR_CTL0 : `CIT_ADDR_CTL1;

        // write strobes, any time, any value
        assign cnt_wr[i] = csr_req.wr && (csr_req.addr == ADDR_CNT);
        assign bnd_wr[i] = csr_req.wr && (csr_req.addr == ADDR_BND);
        assign ctl_wr[i] = csr_req.wr && (csr_req.addr == ADDR_CTL);

        // increment gate; debug step counts every cycle it lasts
        assign inc_ok[i] = ctl[i].enable
            && (!core_state.sleep_state || ctl[i].halt_en)
            && (!core_state.pause || ctl[i].pause_en)
            && (!core_state.debug_mode || core_state.debug_step);

        // requests seen by the arbiter, gated by mie
        assign irq_req[i] = hit[i] && timer_irq_enable[i];
        assign halt_wake[i] = irq_req[i] && ctl[i].halt_en;
        assign pause_wake[i] = irq_req[i] && ctl[i].pause_en;

        cit_timer #(
            .CW(CW)
        ) u_timer (
            .core_clk(core_clk),
            .nrst(nrst),
            .inc_ok(inc_ok[i]),
            .cnt_wr(cnt_wr[i]),
            .bnd_wr(bnd_wr[i]),
            .ctl_wr(ctl_wr[i]),
            .wdata(csr_req.wdata[CW-1:0]),
            .count(count[i]),
            .bound(bound[i]),
            .ctl(ctl[i]),
            .hit(hit[i])
        );
    end

    // ----------------------------------------
    // csr read mux
    // ----------------------------------------
    // narrow control reads zero above bit 2; unmapped reads zero, no hit
    always_comb begin
        next_rdata = 32'h00000000;
        next_hit = 1'b1;
        unique case (csr_req.addr)
            `CIT_ADDR_COUNT0: next_rdata = 32'(count[0]);
            `CIT_ADDR_BOUND0: next_rdata = 32'(bound[0]);
            `CIT_ADDR_CTL0: next_rdata = {29'h00000000, ctl[0]};
            `CIT_ADDR_COUNT1: next_rdata = 32'(count[1]);
            `CIT_ADDR_BOUND1: next_rdata = 32'(bound[1]);
            `CIT_ADDR_CTL1: next_rdata = {29'h00000000, ctl[1]};
            default: next_hit = 1'b0;
        endcase
    end

    // read answer one cycle after the request, held until the next one
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            csr_rdata <= 32'h00000000;
            csr_hit <= 1'b0;
        end else if (csr_req.rd) begin
            csr_rdata <= next_rdata;
            csr_hit <= next_hit;
        end
    end

    // ----------------------------------------
    // pending bits
    // ----------------------------------------
    // not latched: follows the hit, which the clear removes next cycle
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            timer_irq_pending <= 32'h00000000;
        end else begin
            timer_irq_pending <= '0;
            timer_irq_pending[`CIT_IRQ_T0_BIT] <= hit[0];
            timer_irq_pending[`CIT_IRQ_T1_BIT] <= hit[1];
        end
    end

    // ----------------------------------------
    // interrupt ranking
    // ----------------------------------------
    // standard sources first, then timer 0 ahead of timer 1
    always_comb begin
        next_take = 1'b1;
        next_cause = `CIT_CAUSE_NONE;
        if (std_irq.ext) begin
            next_cause = `CIT_CAUSE_EXT;
        end else if (std_irq.sw) begin
            next_cause = `CIT_CAUSE_SW;
        end else if (std_irq.tmr) begin
            next_cause = `CIT_CAUSE_TMR;
        end else if (irq_req[0]) begin
            next_cause = `CIT_CAUSE_T0;
        end else if (irq_req[1]) begin
            next_cause = `CIT_CAUSE_T1;
        end else begin
            next_take = 1'b0;
        end
    end

    // one cycle take strobe with its cause; a missed timer pulse is gone
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_take <= 1'b0;
            irq_cause <= `CIT_CAUSE_NONE;
        end else begin
            irq_take <= next_take;
            irq_cause <= next_cause;
        end
    end

    // ----------------------------------------
    // wake and pause exit
    // ----------------------------------------
    // debug halt blocks both: the debugger owns the core there
    assign next_wake = core_state.sleep_state && !core_state.debug_halted_state
        && (|halt_wake);
    assign next_pause_exit = core_state.pause && !core_state.debug_halted_state
        && (|pause_wake);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sleep_wake <= 1'b0;
            pause_exit <= 1'b0;
        end else begin
            sleep_wake <= next_wake;
            pause_exit <= next_pause_exit;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // a hit on timer 0 with no software write in the way
    sequence s_hit0;
        hit[0] && !cnt_wr[0];
    endsequence

    // timer 0 advancing freely below its bound
    sequence s_step0;
        inc_ok[0] && !hit[0] && !cnt_wr[0];
    endsequence

    // both timers request together with no standard source
    sequence s_both_timers;
        irq_req[0] && irq_req[1] && !std_irq.ext && !std_irq.sw && !std_irq.tmr;
    endsequence

    // nothing at all asks for an interrupt
    sequence s_no_source;
        !irq_req[0] && !irq_req[1] && !std_irq.ext && !std_irq.sw && !std_irq.tmr;
    endsequence

    a_count_advance: assert property (
        s_step0 |=> count[0] == $past(count[0]) + CW'(1)
    ) else $error("timer 0 did not advance by one");

    a_count_hold: assert property (
        !inc_ok[0] && !hit[0] && !cnt_wr[0] |=> $stable(count[0])
    ) else $error("timer 0 moved without increment conditions");

    a_debug_freeze: assert property (
        core_state.debug_mode && !core_state.debug_step && !hit[1] && !cnt_wr[1]
        |=> $stable(count[1])
    ) else $error("timer 1 counted in debug mode without stepping");

    a_step_counts: assert property (
        (core_state.debug_mode && core_state.debug_step && ctl[1].enable
        && !core_state.sleep_state && !core_state.pause && !hit[1] && !cnt_wr[1]) [*2]
        |=> count[1] == $past(count[1], 2) + CW'(2)
    ) else $error("stepped cycles not all counted");

    a_hit_clear: assert property (
        s_hit0 |=> count[0] == '0
    ) else $error("timer 0 not cleared after bound hit");

    a_irq_pulse: assert property (
        s_hit0 ##1 !hit[0] |-> timer_irq_pending[`CIT_IRQ_T0_BIT] ##1 !timer_irq_pending[`CIT_IRQ_T0_BIT]
    ) else $error("timer 0 pending not a single cycle pulse");

    a_irq_follow: assert property (
        hit[1] |=> timer_irq_pending[`CIT_IRQ_T1_BIT] && !timer_irq_pending[`CIT_IRQ_T0_BIT] == !$past(hit[0])
    ) else $error("pending bits do not follow the bound compare");

    a_timer_order: assert property (
        s_both_timers |=> irq_take && irq_cause == `CIT_CAUSE_T0
    ) else $error("timer 1 taken ahead of timer 0");

    a_std_rank: assert property (
        irq_req[0] && std_irq.sw && !std_irq.ext |=> irq_cause == `CIT_CAUSE_SW
    ) else $error("timer ranked above software interrupt");

    a_cause_t1: assert property (
        irq_req[1] && !irq_req[0] && !std_irq.ext && !std_irq.sw && !std_irq.tmr
        |=> irq_cause == `CIT_CAUSE_T1
    ) else $error("wrong cause for timer 1");

    a_write_wins: assert property (
        cnt_wr[0] |=> count[0] == $past(csr_req.wdata[CW-1:0])
    ) else $error("counter write lost to increment or clear");

    a_ctl_reserved: assert property (
        csr_req.rd && csr_req.addr == `CIT_ADDR_CTL1 |=> csr_hit && csr_rdata[31:3] == 29'h00000000
    ) else $error("reserved control bits read non zero");

    a_reset_values: assert property (
        !$past(nrst) |-> count[0] == '0 && bound[1] == CW'(`CIT_BOUND_RESET)
        && ctl[0] == cit_pkg::cit_ctl_s'(`CIT_CTL_RESET)
    ) else $error("reset values wrong after release");

    a_halt_no_wake: assert property (
        core_state.debug_halted_state |=> !sleep_wake && !pause_exit
    ) else $error("timer woke core out of debug halt");

    a_sleep_wake: assert property (
        core_state.sleep_state && !core_state.debug_halted_state && irq_req[0] && ctl[0].halt_en
        |=> sleep_wake
    ) else $error("timer interrupt failed to wake sleeping core");

    a_bound_write: assert property (
        bnd_wr[1] |=> bound[1] == $past(csr_req.wdata[CW-1:0])
    ) else $error("bound write not stored");

    a_first_step: assert property (
        $rose(nrst) && inc_ok[1] && !cnt_wr[1] |=> count[1] == CW'(1)
    ) else $error("timer 1 did not count on the first cycle after reset");

    a_enable_off: assert property (
        !ctl[1].enable && !hit[1] && !cnt_wr[1] |=> $stable(count[1])
    ) else $error("timer 1 counted with enable clear");

    a_irq_gate: assert property (
        !mie[`CIT_IRQ_T0_BIT] && !mie[`CIT_IRQ_T1_BIT] && !std_irq.ext && !std_irq.sw && !std_irq.tmr
        |=> !irq_take && !sleep_wake && !pause_exit
    ) else $error("timer interrupt taken while disabled");

    a_pause_exit: assert property (
        core_state.pause && !core_state.debug_halted_state && irq_req[1] && ctl[1].pause_en
        |=> pause_exit
    ) else $error("timer interrupt failed to end pause");

    a_take_idle: assert property (
        s_no_source |=> !irq_take && irq_cause == `CIT_CAUSE_NONE
    ) else $error("interrupt taken with no source");

    a_cause_t0: assert property (
        irq_req[0] && !std_irq.ext && !std_irq.sw && !std_irq.tmr
        |=> irq_take && irq_cause == `CIT_CAUSE_T0
    ) else $error("wrong cause for timer 0");

    a_ctl_write: assert property (
        ctl_wr[0] |=> ctl[0] == cit_pkg::cit_ctl_s'($past(csr_req.wdata[`CIT_CTL_WIDTH-1:0]))
    ) else $error("control write not stored");

    a_reset_t1: assert property (
        !$past(nrst) |-> count[1] == '0 && bound[0] == CW'(`CIT_BOUND_RESET)
        && ctl[1] == cit_pkg::cit_ctl_s'(`CIT_CTL_RESET)
    ) else $error("second timer reset values wrong");

endmodule

`default_nettype wire

// ==== testbench/cit_timers_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cit_params.svh"

module cit_timers_tb;
    // --------
    // hookup
    // --------
    logic core_clk;
    logic nrst;
    cit_pkg::cit_csr_req_s csr_req;
    cit_pkg::cit_core_state_s core_state;
    cit_pkg::cit_std_irq_s std_irq;
    logic [31:0] mie;
    logic [31:0] csr_rdata;
    logic csr_hit;
    logic [31:0] timer_irq_pending;
    logic irq_take;
    logic [31:0] irq_cause;
    logic sleep_wake;
    logic pause_exit;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    int i;
    int g;

    cit_timers #(.CW(32)) dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .csr_req(csr_req),
        .csr_rdata(csr_rdata),
        .csr_hit(csr_hit),
        .core_state(core_state),
        .mie(mie),
        .std_irq(std_irq),
        .timer_irq_pending(timer_irq_pending),
        .irq_take(irq_take),
        .irq_cause(irq_cause),
        .sleep_wake(sleep_wake),
        .pause_exit(pause_exit)
    );

    // --------
    // reference model
    // --------
    logic [31:0] m_cnt [2];
    logic [31:0] m_bnd [2];
    logic [2:0] m_ctl [2];
    logic [31:0] m_rdata;
    logic [31:0] m_pend;
    logic [31:0] m_cause;
    logic m_hit;
    logic m_take;
    logic m_wake;
    logic m_pexit;

    // one step per edge; a read sees the values from before this edge's write
    always @(posedge core_clk) begin : model_step
        logic [11:0] b;
        logic [31:0] rv;
        logic h [2];
        logic e [2];
        logic inc;
        logic wk;
        logic px;
        if (!nrst) begin
            for (int k = 0; k < 2; k++) begin
                m_cnt[k] <= `CIT_COUNT_RESET;
                m_bnd[k] <= `CIT_BOUND_RESET;
                m_ctl[k] <= `CIT_CTL_RESET;
            end
            m_rdata <= 32'h0;
            m_hit <= 1'b0;
            m_pend <= 32'h0;
            m_take <= 1'b0;
            m_cause <= 32'h0;
            m_wake <= 1'b0;
            m_pexit <= 1'b0;
        end else begin
            rv = 32'h0;
            wk = 1'b0;
            px = 1'b0;
            for (int k = 0; k < 2; k++) begin
                b = k ? `CIT_ADDR_COUNT1 : `CIT_ADDR_COUNT0;
                if (csr_req.addr == b) rv = m_cnt[k];
                if (csr_req.addr == b + 12'h1) rv = m_bnd[k];
                if (csr_req.addr == b + 12'h2) rv = {29'h0, m_ctl[k]};
                h[k] = m_cnt[k] >= m_bnd[k];
                inc = m_ctl[k][0] && (!core_state.sleep_state || m_ctl[k][1]) && (!core_state.pause || m_ctl[k][2])
                    && (!core_state.debug_mode || core_state.debug_step);
                if (csr_req.wr && csr_req.addr == b) m_cnt[k] <= csr_req.wdata;
                else if (h[k]) m_cnt[k] <= 32'h0;
                else if (inc) m_cnt[k] <= m_cnt[k] + 32'h1;
                if (csr_req.wr && csr_req.addr == b + 12'h1) m_bnd[k] <= csr_req.wdata;
                if (csr_req.wr && csr_req.addr == b + 12'h2) m_ctl[k] <= csr_req.wdata[2:0];
                e[k] = h[k] && mie[29 - k];
                wk = wk || (e[k] && m_ctl[k][1]);
                px = px || (e[k] && m_ctl[k][2]);
            end
            if (csr_req.rd) begin
                m_rdata <= rv;
                m_hit <= csr_req.addr >= `CIT_ADDR_COUNT0 && csr_req.addr <= `CIT_ADDR_CTL1;
            end
            m_pend <= {2'h0, h[0], h[1], 28'h0};
            m_take <= std_irq.ext || std_irq.sw || std_irq.tmr || e[0] || e[1];
            if (std_irq.ext) m_cause <= `CIT_CAUSE_EXT;
            else if (std_irq.sw) m_cause <= `CIT_CAUSE_SW;
            else if (std_irq.tmr) m_cause <= `CIT_CAUSE_TMR;
            else if (e[0]) m_cause <= `CIT_CAUSE_T0;
            else if (e[1]) m_cause <= `CIT_CAUSE_T1;
            else m_cause <= `CIT_CAUSE_NONE;
            m_wake <= wk && core_state.sleep_state && !core_state.debug_halted_state;
            m_pexit <= px && core_state.pause && !core_state.debug_halted_state;
        end
    end

    // --------
    // checking
    // --------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // every output against the model once the edge's updates have landed
    always @(posedge core_clk) begin
        #1;
        cycles++;
        chk_word(csr_rdata, m_rdata);
        chk_flag(csr_hit, m_hit);
        chk_word(timer_irq_pending, m_pend);
        chk_flag(irq_take, m_take);
        chk_word(irq_cause, m_cause);
        chk_flag(sleep_wake, m_wake);
        chk_flag(pause_exit, m_pexit);
        // a hang ends the run as a mismatch
        if (cycles > 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // --------
    // stimulus
    // --------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #2;
        end
    endtask

    // one request for one cycle; calls may follow back to back
    task automatic csr(input logic rd, input logic wr, input logic [11:0] a, input logic [31:0] d);
        csr_req = {rd, wr, a, d};
        tick(1);
    endtask

    task automatic idle(input int n);
        csr_req = '0;
        tick(n);
    endtask

    // reads around the mapped range, edges included
    task automatic rd_all();
        for (int k = 0; k < 8; k++) csr(1'b1, 1'b0, 12'h7D1 + 12'(k), 32'h0);
        csr(1'b1, 1'b0, 12'h7F2, 32'h0);
    endtask

    initial begin
        nrst = 1'b0;
        csr_req = '0;
        core_state = '0;
        mie = 32'h0;
        std_irq = '0;
        void'($urandom(42963));
        tick(8);
        nrst = 1'b1;
        rd_all();
        for (i = 0; i < 6; i++) begin
            csr(1'b0, 1'b1, 12'h7D2 + 12'(i), $urandom());
            csr(1'b1, 1'b1, 12'h7D2 + 12'(i), $urandom());
            csr(1'b1, 1'b0, 12'h7D2 + 12'(i), 32'h0);
        end
        // second reset in mid-run must restore every value
        nrst = 1'b0;
        idle(2);
        nrst = 1'b1;
        rd_all();
        // both timers brought into step so their hits coincide
        mie = 32'hFFFFFFFF;
        csr(1'b0, 1'b1, `CIT_ADDR_BOUND0, 32'h3);
        csr(1'b0, 1'b1, `CIT_ADDR_BOUND1, 32'h3);
        csr(1'b0, 1'b1, `CIT_ADDR_COUNT0, 32'h0);
        csr(1'b0, 1'b1, `CIT_ADDR_COUNT1, 32'h1);
        for (i = 0; i < 8; i++) begin
            std_irq = cit_pkg::cit_std_irq_s'(i[2:0]);
            idle(4);
        end
        std_irq = '0;
        // a write lands in the very cycle of a hit
        csr(1'b0, 1'b1, `CIT_ADDR_COUNT0, 32'h3);
        csr(1'b0, 1'b1, `CIT_ADDR_COUNT0, 32'h2);
        csr(1'b1, 1'b0, `CIT_ADDR_COUNT0, 32'h0);
        // zero bound hits every cycle
        csr(1'b0, 1'b1, `CIT_ADDR_BOUND1, 32'h0);
        idle(4);
        // every mix of control bits and core states
        for (g = 0; g < 256; g++) begin
            core_state = cit_pkg::cit_core_state_s'(g[7:3]);
            mie = $urandom();
            csr(1'b0, 1'b1, `CIT_ADDR_CTL0, 32'(g));
            csr(1'b0, 1'b1, `CIT_ADDR_CTL1, ~32'(g));
            csr(1'b0, 1'b1, `CIT_ADDR_BOUND0, 32'h2);
            csr(1'b0, 1'b1, `CIT_ADDR_BOUND1, 32'h3);
            idle(4);
            csr(1'b1, 1'b0, `CIT_ADDR_COUNT0, 32'h0);
        end
        // random traffic with small values so hits stay frequent
        for (i = 0; i < 3000; i++) begin
            core_state = cit_pkg::cit_core_state_s'(5'($urandom_range(0, 31)));
            std_irq = cit_pkg::cit_std_irq_s'(3'(($urandom_range(0, 3) == 0) ? $urandom_range(1, 7) : 0));
            mie = $urandom();
            nrst = (i != 1500);
            csr(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)), 12'h7D1 + 12'($urandom_range(0, 7)),
                32'($urandom_range(0, 9)));
        end
        idle(2);
        report_and_stop();
    end
endmodule

`default_nettype wire
